// ===== src/asfe_pkg.sv
/*
 * Constants shared by the asynchronous serial frame engine: register
 * offsets, field positions, encodings, reset values and tick counts.
 * Assumes a 16-bit register port with word offsets in steps of four.
 */
package asfe_pkg;
	// Register port widths
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int DIV_W = 8;
	// Register offsets
	localparam logic [4:0] ADDR_MODE = 5'h00;
	localparam logic [4:0] ADDR_DIV = 5'h04;
	localparam logic [4:0] ADDR_CTRL = 5'h08;
	localparam logic [4:0] ADDR_STAT = 5'h0C;
	localparam logic [4:0] ADDR_TXBUF = 5'h10;
	localparam logic [4:0] ADDR_RXBUF = 5'h14;
	// Mode register fields
	localparam int MODE_SMD_LSB = 0;
	localparam int MODE_CKS_LSB = 3;
	localparam int MODE_STOP2 = 5;
	localparam int MODE_PAR_EN = 6;
	localparam int MODE_PAR_ODD = 7;
	// Control register fields
	localparam int CTRL_TE = 0;
	localparam int CTRL_RE = 1;
	// Status register fields
	localparam int STAT_TXB_EMPTY = 0;
	localparam int STAT_TX_IDLE = 1;
	localparam int STAT_RX_FULL = 2;
	localparam int STAT_OER = 3;
	localparam int STAT_FER = 4;
	localparam int STAT_PER = 5;
	localparam int STAT_SUM = 6;
	// Receive buffer error fields
	localparam int RXB_OER = 12;
	localparam int RXB_FER = 13;
	localparam int RXB_PER = 14;
	localparam int RXB_SUM = 15;
	// Mode select encodings
	localparam logic [2:0] SMD_OFF = 3'h0;
	localparam logic [2:0] SMD_7 = 3'h4;
	localparam logic [2:0] SMD_8 = 3'h5;
	localparam logic [2:0] SMD_9 = 3'h6;
	localparam logic [3:0] CHAR_7 = 4'h7;
	localparam logic [3:0] CHAR_8 = 4'h8;
	localparam logic [3:0] CHAR_9 = 4'h9;
	// Count source encodings and prescaler
	localparam logic [1:0] CKS_F1 = 2'h0;
	localparam logic [1:0] CKS_F8 = 2'h1;
	localparam logic [1:0] CKS_F32 = 2'h2;
	localparam logic [1:0] CKS_EXT = 2'h3;
	localparam int PRE_W = 5;
	localparam logic [2:0] PRE8_LAST = 3'h7;
	localparam logic [4:0] PRE32_LAST = 5'h1F;
	// Bit timing in generator ticks, sixteen per bit
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam int FRAME_W = 13;
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] DIV_RST = 8'h00;
endpackage : asfe_pkg

// ===== src/asfe_rate_gen.sv
/*
 * Bit rate divider: picks the count source, divides it by the programmed
 * value plus one and gives one-cycle ticks at sixteen times the bit rate.
 * Assumes the external clock pin is synchronous to ref_clk.
 */
`timescale 1ns/1ps
module asfe_rate_gen #(
	parameter int DIV_W = asfe_pkg::DIV_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Configuration
	input wire logic en,
	input wire logic [1:0] src_sel,
	input wire logic [DIV_W-1:0] div_val,
	// External count source pin
	input wire logic clk_in,
	// Sixteen-per-bit tick
	output logic tick
);
	typedef struct packed {
		logic [asfe_pkg::PRE_W-1:0] pre;
		logic [DIV_W-1:0] cnt;
		logic ext_q;
		logic tick;
	} asfe_rg_state_t;

	asfe_rg_state_t c;
	asfe_rg_state_t n;

	// Refuse divider widths the count logic cannot serve
	if (DIV_W < 1 || DIV_W > 16) begin : g_chk
		$error("asfe_rate_gen: DIV_W out of range");
	end

	// Source select, prescaler and reload divider
	always_comb begin
		logic src;
		src = 1'b0;
		n = c;
		n.tick = 1'b0;
		n.ext_q = clk_in;
		n.pre = c.pre + 1'b1;
		case (src_sel)
			asfe_pkg::CKS_F1: src = 1'b1;
			asfe_pkg::CKS_F8: src = (c.pre[2:0] == asfe_pkg::PRE8_LAST);
			asfe_pkg::CKS_F32: src = (c.pre == asfe_pkg::PRE32_LAST);
			default: src = clk_in && !c.ext_q;
		endcase
		if (!en) begin
			n.cnt = div_val;
			n.pre = '0;
		end else if (src) begin
			if (c.cnt == '0) begin
				n.cnt = div_val;
				n.tick = 1'b1;
			end else begin
				n.cnt = c.cnt - 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			c <= '0;
		end else begin
			c <= n;
		end
	end

	assign tick = c.tick;
endmodule : asfe_rate_gen

// ===== src/asfe_top.sv
/*
 * Asynchronous serial frame engine: register port, transmitter and
 * receiver with 7/8/9 data bits, optional parity, one or two stop bits.
 * Assumes rxd and clk_in are synchronous to ref_clk and rxd idles high.
 */
`timescale 1ns/1ps
module asfe_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register port
	input wire logic [asfe_pkg::ADDR_W-1:0] addr,
	input wire logic [asfe_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [asfe_pkg::DATA_W-1:0] rdata,
	// Serial pins
	input wire logic rxd,
	input wire logic clk_in,
	output logic txd,
	// Receive event
	output logic rx_req
);
	typedef enum logic {TX_IDLE, TX_SEND} asfe_tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asfe_rx_state_t;

	typedef struct packed {
		logic [2:0] smd;
		logic [1:0] cks;
		logic stop2;
		logic par_en;
		logic par_odd;
		logic [7:0] div;
		logic te;
		logic re;
		logic [8:0] txbuf;
		logic txbuf_full;
		asfe_tx_state_t tx_st;
		logic [3:0] tx_tick;
		logic [3:0] tx_bit;
		logic [asfe_pkg::FRAME_W-1:0] tx_sh;
		logic txd;
		asfe_rx_state_t rx_st;
		logic rxd_q;
		logic [3:0] rx_tick;
		logic [3:0] rx_bit;
		logic [8:0] rx_sh;
		logic rx_par;
		logic rx_ferr;
		logic rx_ovr;
		logic [8:0] rxbuf;
		logic rx_full;
		logic oer;
		logic fer;
		logic per;
		logic rx_req;
		logic [asfe_pkg::DATA_W-1:0] rdata;
	} asfe_state_t;

	asfe_state_t c;
	asfe_state_t n;
	logic tick;
	logic rx_xfer;
	logic gen_en;

	function automatic logic asfe_mode_on(input logic [2:0] smd);
		return smd == asfe_pkg::SMD_7 || smd == asfe_pkg::SMD_8 ||
			smd == asfe_pkg::SMD_9;
	endfunction : asfe_mode_on

	function automatic logic [3:0] asfe_char_len(input logic [2:0] smd);
		case (smd)
			asfe_pkg::SMD_7: return asfe_pkg::CHAR_7;
			asfe_pkg::SMD_9: return asfe_pkg::CHAR_9;
			default: return asfe_pkg::CHAR_8;
		endcase
	endfunction : asfe_char_len

	// Whole frame, start bit in bit 0, unused high bits stay high
	function automatic logic [asfe_pkg::FRAME_W-1:0] asfe_build_frame(
		input logic [8:0] d, input logic [3:0] clen,
		input logic pe, input logic podd);
		logic [asfe_pkg::FRAME_W-1:0] f;
		logic p;
		f = '1;
		p = podd;
		f[0] = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(clen)) begin
				f[i + 1] = d[i];
				p = p ^ d[i];
			end
		end
		if (pe) begin
			f[int'(clen) + 1] = p;
		end
		return f;
	endfunction : asfe_build_frame

	assign gen_en = asfe_mode_on(c.smd);

	asfe_rate_gen #(
		.DIV_W(asfe_pkg::DIV_W)
	) u_rate (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.en(gen_en),
		.src_sel(c.cks),
		.div_val(c.div),
		.clk_in(clk_in),
		.tick(tick)
	);

	// Next state: transmitter, bus access, receiver, disables
	always_comb begin
		logic [3:0] clen;
		logic [3:0] tx_last;
		logic [3:0] rx_last;
		logic rx_on;
		clen = asfe_char_len(c.smd);
		tx_last = clen + {3'h0, c.par_en} + 4'h1 + {3'h0, c.stop2};
		rx_last = clen + {3'h0, c.par_en} + {3'h0, c.stop2};
		rx_on = 1'b0;
		n = c;
		n.rx_req = 1'b0;
		n.rdata = '0;
		n.rxd_q = rxd;
		rx_xfer = 1'b0;

		case (c.tx_st)
			TX_IDLE: begin
				if (c.te && c.txbuf_full) begin
					n.tx_sh = asfe_build_frame(c.txbuf, clen,
						c.par_en, c.par_odd);
					n.txbuf_full = 1'b0;
					n.tx_tick = 4'h0;
					n.tx_bit = 4'h0;
					n.tx_st = TX_SEND;
				end
			end
			TX_SEND: begin
				if (tick) begin
					n.tx_tick = c.tx_tick + 4'h1;
					if (c.tx_tick == asfe_pkg::TICK_LAST) begin
						n.tx_sh = {1'b1, c.tx_sh[asfe_pkg::FRAME_W-1:1]};
						n.tx_bit = c.tx_bit + 4'h1;
						if (c.tx_bit == tx_last) begin
							n.tx_st = TX_IDLE;
						end
					end
				end
			end
			default: n.tx_st = TX_IDLE;
		endcase

		// Register writes
		if (wr) begin
			case (addr)
				asfe_pkg::ADDR_MODE: begin
					n.smd = wdata[asfe_pkg::MODE_SMD_LSB +: 3];
					n.cks = wdata[asfe_pkg::MODE_CKS_LSB +: 2];
					n.stop2 = wdata[asfe_pkg::MODE_STOP2];
					n.par_en = wdata[asfe_pkg::MODE_PAR_EN];
					n.par_odd = wdata[asfe_pkg::MODE_PAR_ODD];
				end
				asfe_pkg::ADDR_DIV: n.div = wdata[7:0];
				asfe_pkg::ADDR_CTRL: begin
					n.te = wdata[asfe_pkg::CTRL_TE];
					n.re = wdata[asfe_pkg::CTRL_RE];
				end
				asfe_pkg::ADDR_TXBUF: begin
					n.txbuf = wdata[8:0];
					n.txbuf_full = 1'b1;
				end
				default: ;
			endcase
		end

		// Register reads, data valid the next cycle
		if (rd) begin
			case (addr)
				asfe_pkg::ADDR_MODE: begin
					n.rdata[asfe_pkg::MODE_SMD_LSB +: 3] = c.smd;
					n.rdata[asfe_pkg::MODE_CKS_LSB +: 2] = c.cks;
					n.rdata[asfe_pkg::MODE_STOP2] = c.stop2;
					n.rdata[asfe_pkg::MODE_PAR_EN] = c.par_en;
					n.rdata[asfe_pkg::MODE_PAR_ODD] = c.par_odd;
				end
				asfe_pkg::ADDR_DIV: n.rdata[7:0] = c.div;
				asfe_pkg::ADDR_CTRL: begin
					n.rdata[asfe_pkg::CTRL_TE] = c.te;
					n.rdata[asfe_pkg::CTRL_RE] = c.re;
				end
				asfe_pkg::ADDR_STAT: begin
					n.rdata[asfe_pkg::STAT_TXB_EMPTY] = !c.txbuf_full;
					n.rdata[asfe_pkg::STAT_TX_IDLE] = c.tx_st == TX_IDLE;
					n.rdata[asfe_pkg::STAT_RX_FULL] = c.rx_full;
					n.rdata[asfe_pkg::STAT_OER] = c.oer;
					n.rdata[asfe_pkg::STAT_FER] = c.fer;
					n.rdata[asfe_pkg::STAT_PER] = c.per;
					n.rdata[asfe_pkg::STAT_SUM] = c.oer | c.fer | c.per;
				end
				asfe_pkg::ADDR_RXBUF: begin
					n.rdata[8:0] = c.rxbuf;
					n.rdata[asfe_pkg::RXB_OER] = c.oer;
					n.rdata[asfe_pkg::RXB_FER] = c.fer;
					n.rdata[asfe_pkg::RXB_PER] = c.per;
					// sum clears only with all flags
					n.rdata[asfe_pkg::RXB_SUM] = c.oer | c.fer | c.per;
					n.rx_full = 1'b0;
					n.fer = 1'b0;
					n.per = 1'b0;
				end
				default: ;
			endcase
		end

		// Receiver, applied after the bus so a transfer wins over a clear
		case (c.rx_st)
			RX_IDLE: begin
				if (c.rxd_q && !rxd) begin
					n.rx_tick = 4'h0;
					n.rx_st = RX_START;
				end
			end
			RX_START: begin
				if (tick) begin
					n.rx_tick = c.rx_tick + 4'h1;
					if (c.rx_tick == asfe_pkg::TICK_MID) begin
						// start must still be low mid-bit
						n.rx_st = rxd ? RX_IDLE : RX_BITS;
						n.rx_tick = 4'h0;
						n.rx_bit = 4'h0;
						n.rx_sh = '0;
						n.rx_par = 1'b0;
						n.rx_ferr = 1'b0;
						n.rx_ovr = 1'b0;
					end
				end
			end
			RX_BITS: begin
				if (tick) begin
					n.rx_tick = c.rx_tick + 4'h1;
					if (c.rx_tick == asfe_pkg::TICK_LAST) begin
						n.rx_bit = c.rx_bit + 4'h1;
						if (c.rx_bit < clen) begin
							n.rx_sh[c.rx_bit] = rxd;
							n.rx_par = c.rx_par ^ rxd;
						end else if (c.par_en && c.rx_bit == clen) begin
							n.rx_par = c.rx_par ^ rxd;
						end else if (!rxd) begin
							n.rx_ferr = 1'b1;
						end
						if (c.rx_bit == rx_last - 4'h1 && c.rx_full) begin
							n.rx_ovr = 1'b1;
						end
						if (c.rx_bit == rx_last) begin
							rx_xfer = 1'b1;
							n.rxbuf = n.rx_sh;
							n.oer = c.oer | n.rx_ovr;
							n.fer = n.rx_ferr;
							n.per = c.par_en && (n.rx_par != c.par_odd);
							n.rx_full = 1'b1;
							n.rx_req = !n.rx_ovr;
							n.rx_st = RX_IDLE;
						end
					end
				end
			end
			default: n.rx_st = RX_IDLE;
		endcase

		if (!asfe_mode_on(n.smd)) begin
			n.tx_st = TX_IDLE;
			n.txbuf_full = 1'b0;
		end
		// mode off or receive off clears errors
		rx_on = n.re && asfe_mode_on(n.smd);
		if (!rx_on) begin
			n.rx_st = RX_IDLE;
			n.rx_full = 1'b0;
			n.oer = 1'b0;
			n.fer = 1'b0;
			n.per = 1'b0;
		end
		n.txd = (n.tx_st == TX_SEND) ? n.tx_sh[0] : 1'b1;
	end

	// State register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			c <= '0;
			c.smd <= asfe_pkg::MODE_RST[2:0];
			c.div <= asfe_pkg::DIV_RST;
			c.txd <= 1'b1;
			c.rxd_q <= 1'b1;
		end else begin
			c <= n;
		end
	end

	// Outputs straight from flip-flops
	assign txd = c.txd;
	assign rdata = c.rdata;
	assign rx_req = c.rx_req;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	property p_tx_idle_high;
		c.tx_st == TX_IDLE |-> txd;
	endproperty
	a_tx_idle_high: assert property (p_tx_idle_high)
		else $error("txd low while transmitter idle");

	property p_tx_start_low;
		c.tx_st == TX_IDLE ##1 c.tx_st == TX_SEND |-> !txd && c.tx_bit == 4'h0;
	endproperty
	a_tx_start_low: assert property (p_tx_start_low)
		else $error("frame did not open with a low start bit");

	property p_tx_bit_hold;
		c.tx_st == TX_SEND && !(tick && c.tx_tick == asfe_pkg::TICK_LAST)
			|=> $stable(txd);
	endproperty
	a_tx_bit_hold: assert property (p_tx_bit_hold)
		else $error("txd changed inside a bit period");

	property p_tx_stop_high;
		c.tx_st == TX_SEND && c.tx_bit > asfe_char_len(c.smd) +
			{3'h0, c.par_en} |-> txd;
	endproperty
	a_tx_stop_high: assert property (p_tx_stop_high)
		else $error("stop bit not high");

	property p_err_at_xfer;
		$rose(c.oer) || $rose(c.fer) || $rose(c.per) |-> $past(rx_xfer);
	endproperty
	a_err_at_xfer: assert property (p_err_at_xfer)
		else $error("error flag set outside a buffer transfer");

	property p_sum_read;
		rd && addr == asfe_pkg::ADDR_RXBUF |=>
			rdata[asfe_pkg::RXB_SUM] == ($past(c.oer) | $past(c.fer) |
			$past(c.per));
	endproperty
	a_sum_read: assert property (p_sum_read)
		else $error("error sum does not match flags");

	property p_disable_clear;
		!c.re || !asfe_mode_on(c.smd) |-> !c.oer && !c.fer && !c.per;
	endproperty
	a_disable_clear: assert property (p_disable_clear)
		else $error("error flags held while receiver off");

	property p_read_clear;
		rd && addr == asfe_pkg::ADDR_RXBUF && !rx_xfer |=>
			!c.fer && !c.per && (c.oer || !$past(c.oer) || !c.re);
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("buffer read did not clear flags as expected");

	property p_ovr_noreq;
		rx_xfer && n.rx_ovr && n.re && asfe_mode_on(n.smd) |=>
			!rx_req && c.oer;
	endproperty
	a_ovr_noreq: assert property (p_ovr_noreq)
		else $error("overrun raised a receive request");

	c_tx_frame: cover property (c.tx_st == TX_SEND ##1 c.tx_st == TX_IDLE);
	c_rx_req: cover property (rx_req);
	c_overrun: cover property ($rose(c.oer));
	c_framing: cover property ($rose(c.fer));
endmodule : asfe_top

// ===== test/asfe_peer.sv
/*
 * Remote serial partner: sends frames on rxd, decodes frames from txd.
 * Assumes the bench sets format and bit period in ref_clk cycles.
 */
`timescale 1ns/1ps
module asfe_peer (
	// Clock
	input wire logic ref_clk,
	// Serial lines
	input wire logic txd,
	output logic rxd,
	// Frame format
	input wire logic [3:0] nbits,
	input wire logic pe,
	input wire logic podd,
	input wire logic stop2,
	input wire logic [15:0] bit_cyc,
	// Decoded frame
	output logic got,
	output logic [8:0] got_data,
	output logic got_bad
);
	logic [8:0] d;
	logic bad;

	// Holds one bit for a full bit period
	task automatic put(input logic b);
		rxd <= b;
		repeat (bit_cyc) @(posedge ref_clk);
	endtask : put

	// Sends one frame, optionally with a parity or stop fault
	task automatic send(input logic [8:0] c, input logic bp,
		input logic bs);
		logic par;
		par = ^(c & 9'((1 << nbits) - 1)) ^ podd ^ bp;
		put(1'b0);
		// data bits from bit 0 upward
		for (int i = 0; i < nbits; i++) begin
			put(c[i]);
		end
		if (pe) begin
			put(par);
		end
		// high stop bits; first may be forced low
		put(~bs);
		if (stop2) begin
			put(1'b1);
		end
		// Line back to idle after a forced low stop bit
		if (bs) begin
			put(1'b1);
		end
	endtask : send

	// Receiver: falling edge, then mid-bit samples
	initial begin
		rxd = 1'b1;
		got = 1'b0;
		got_data = '0;
		got_bad = 1'b0;
		forever begin
			// idle high until a start edge
			@(negedge txd);
			repeat (bit_cyc / 2) @(posedge ref_clk);
			bad = txd;
			d = '0;
			for (int i = 0; i < nbits; i++) begin
				repeat (bit_cyc) @(posedge ref_clk);
				d[i] = txd;
			end
			if (pe) begin
				repeat (bit_cyc) @(posedge ref_clk);
				bad = bad | (^d ^ txd ^ podd);
			end
			repeat (bit_cyc) @(posedge ref_clk);
			bad = bad | ~txd;
			if (stop2) begin
				repeat (bit_cyc) @(posedge ref_clk);
				bad = bad | ~txd;
			end
			got_data <= d;
			got_bad <= bad;
			got <= 1'b1;
			@(posedge ref_clk);
			got <= 1'b0;
		end
	end
endmodule : asfe_peer

// ===== test/tb_asfe_top.sv
/*
 * Self-checking bench for the serial frame engine.
 * Assumes the peer model on the serial pins and a 10 MHz clock.
 */
`timescale 1ns/1ps
module tb_asfe_top;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [asfe_pkg::ADDR_W-1:0] addr = '0;
	logic [15:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic clk_in = 1'b0;
	logic [15:0] rdata, v, bit_cyc = 16'h0010;
	logic rxd, txd, rx_req, got, got_bad, pe = 1'b0, podd = 1'b0;
	logic stop2 = 1'b0;
	logic [8:0] got_data, d, cm;
	logic [3:0] nbits = 4'h8;
	logic [31:0] seed = 32'h0000_72ed;
	int err_count = 0, samples_checked = 0;
	int rx_cnt = 0, tx_cnt = 0, rx_t = 0, tx_t = 0, lows = 0, n;
	int pre[4] = '{1, 8, 32, 2};
	logic [8:0] exp_q[$];

	asfe_top DUT (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd),
		.clk_in(clk_in), .txd(txd), .rx_req(rx_req));
	asfe_peer peer (.ref_clk(ref_clk), .txd(txd), .rxd(rxd),
		.nbits(nbits), .pe(pe), .podd(podd), .stop2(stop2),
		.bit_cyc(bit_cyc), .got(got), .got_data(got_data),
		.got_bad(got_bad));

	// Clock, external count source and event counters
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		clk_in <= ~clk_in;
		if (rx_req === 1'b1) rx_cnt++;
		if (txd !== 1'b1) lows++;
	end

	// Transmit side: each decoded frame against the oldest note
	always @(posedge ref_clk) begin
		if (got === 1'b1) begin
			if (exp_q.size() == 0) begin
				fail("unexpected frame");
			end else begin
				check(16'(got_data), 16'(exp_q.pop_front()));
				check(16'(got_bad), 16'h0000);
			end
			tx_cnt++;
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic fail(input string msg);
		err_count++;
		$display("ERROR %0t %s", $time, msg);
	endtask : fail

	task automatic check(input logic [15:0] seen, input logic [15:0] ex);
		samples_checked++;
		if (seen !== ex) begin
			fail($sformatf("saw %h expected %h", seen, ex));
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	// Register port cycles
	task automatic reg_wr(input logic [4:0] a, input logic [15:0] x);
		@(posedge ref_clk);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [4:0] a, output logic [15:0] x);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		x = rdata;
	endtask : reg_rd

	// Bounded wait for receive requests and decoded frames
	task automatic wait_done();
		int k;
		k = 0;
		while ((rx_cnt < rx_t || tx_cnt < tx_t) && k < 40000) begin
			@(posedge ref_clk);
			k++;
		end
		// Let the last stop bit finish before the format changes
		repeat (bit_cyc) @(posedge ref_clk);
		if (k >= 40000) begin
			fail("no completion");
			report_and_stop();
		end
	endtask : wait_done

	task automatic wait_txd(input logic lvl, output int k);
		k = 0;
		while (txd !== lvl && k < 5000) begin
			@(posedge ref_clk);
			k++;
		end
		if (k >= 5000) begin
			fail("txd stuck");
			report_and_stop();
		end
	endtask : wait_txd

	// Programs format and rate on both ends
	task automatic set_fmt(input int len, input int par, input logic s2,
		input logic [1:0] src, input logic [7:0] dv);
		logic [2:0] smd;
		smd = (len == 7) ? asfe_pkg::SMD_7 :
			(len == 8) ? asfe_pkg::SMD_8 : asfe_pkg::SMD_9;
		nbits = 4'(len);
		pe = (par != 0);
		podd = (par == 2);
		stop2 = s2;
		cm = 9'((1 << len) - 1);
		bit_cyc = 16'(16 * (dv + 1) * pre[src]);
		reg_wr(asfe_pkg::ADDR_DIV, {8'h00, dv});
		reg_wr(asfe_pkg::ADDR_MODE, {8'h00, podd, pe, s2, src, smd});
	endtask : set_fmt

	initial begin
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		check(16'(txd), 16'h0001);
		reg_rd(asfe_pkg::ADDR_MODE, v);
		check(v, 16'h0000);
		reg_rd(5'h1C, v);
		check(v, 16'h0000);
		$display("test reset done");
		reg_wr(asfe_pkg::ADDR_CTRL, 16'h0003);
		// Every format, sending and receiving at once
		for (int len = 7; len <= 9; len++) begin
			for (int p = 0; p < 3; p++) begin
				for (int s = 0; s < 2; s++) begin
					set_fmt(len, p, s[0], asfe_pkg::CKS_F1, 8'h00);
					d = 9'(xs()) & cm;
					exp_q.push_back(9'(xs()) & cm);
					rx_t++;
					tx_t++;
					fork
						peer.send(d, 1'b0, 1'b0);
						reg_wr(asfe_pkg::ADDR_TXBUF, 16'(exp_q[0]));
					join
					wait_done();
					reg_rd(asfe_pkg::ADDR_RXBUF, v);
					check(v & {7'h78, cm}, 16'(d));
				end
			end
		end
		$display("test formats done");
		// Framing then parity fault, each cleared by a buffer read
		set_fmt(8, 1, 1'b0, asfe_pkg::CKS_F1, 8'h00);
		for (int k = 0; k < 2; k++) begin
			d = 9'(xs()) & cm;
			rx_t++;
			peer.send(d, k[0], ~k[0]);
			wait_done();
			reg_rd(asfe_pkg::ADDR_RXBUF, v);
			check(v & 16'hF0FF, (k ? 16'hC000 : 16'hA000) | 16'(d));
			reg_rd(asfe_pkg::ADDR_RXBUF, v);
			check(v & 16'hF000, 16'h0000);
			reg_rd(asfe_pkg::ADDR_STAT, v);
			check(16'(v[6:3]), 16'h0000);
		end
		$display("test errors done");
		// Overrun: two frames with no read between
		rx_t++;
		peer.send(9'(xs()) & cm, 1'b0, 1'b0);
		peer.send(9'(xs()) & cm, 1'b0, 1'b0);
		repeat (20) @(posedge ref_clk);
		check(16'(rx_cnt), 16'(rx_t));
		reg_rd(asfe_pkg::ADDR_STAT, v);
		check(16'(v[6:3]), 16'h0009);
		reg_rd(asfe_pkg::ADDR_RXBUF, v);
		check(16'(v[15:12]), 16'h0009);
		reg_rd(asfe_pkg::ADDR_STAT, v);
		check(16'(v[6:3]), 16'h0009);
		reg_wr(asfe_pkg::ADDR_CTRL, 16'h0001);
		reg_rd(asfe_pkg::ADDR_STAT, v);
		check(16'(v[6:3]), 16'h0000);
		reg_wr(asfe_pkg::ADDR_CTRL, 16'h0003);
		$display("test overrun done");
		// Channel off: no frame either way
		reg_wr(asfe_pkg::ADDR_MODE, 16'h0000);
		n = lows;
		fork
			peer.send(9'h0A5, 1'b0, 1'b0);
			reg_wr(asfe_pkg::ADDR_TXBUF, 16'h00A5);
		join
		check(16'(lows - n), 16'h0000);
		check(16'(rx_cnt), 16'(rx_t));
		$display("test off done");
		// Bit width for each count source at divider value one
		for (int src = 0; src < 4; src++) begin
			set_fmt(8, 0, 1'b0, 2'(src), 8'h01);
			exp_q.push_back(9'h055);
			tx_t++;
			reg_wr(asfe_pkg::ADDR_TXBUF, 16'h0055);
			wait_txd(1'b0, n);
			wait_txd(1'b1, n);
			wait_txd(1'b0, n);
			check(16'(n), bit_cyc);
			wait_done();
		end
		$display("test rates done");
		report_and_stop();
	end
endmodule : tb_asfe_top
